// >>> logic/ascm_pkg.sv
// Constants, field layout and types of the scan configuration memory block
package ascm_pkg;

  // Entry store geometry
  localparam int unsigned ASCM_EW = 16;
  localparam int unsigned ASCM_AW = 9;
  localparam int unsigned ASCM_DEPTH = 512;
  localparam logic [9:0] ASCM_DEPTH_CNT = 10'h200;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ASCM_IDX_ENTRY = 8'h08;
  localparam logic [7:0] ASCM_IDX_DAQ_CLR = 8'h19;
  localparam logic [7:0] ASCM_IDX_STROBE = 8'h1b;
  localparam logic [7:0] ASCM_IDX_CTRL = 8'h20;
  localparam logic [7:0] ASCM_IDX_STATUS = 8'h21;
  localparam logic [7:0] ASCM_IDX_COUNT = 8'h22;

  // Entry field positions
  localparam int unsigned ASCM_B_SE = 15;
  localparam int unsigned ASCM_B_SENSE = 14;
  localparam int unsigned ASCM_B_CALIB = 13;
  localparam int unsigned ASCM_B_BIPOLAR = 12;
  localparam int unsigned ASCM_B_RSV_HI = 11;
  localparam int unsigned ASCM_B_RSV_LO = 10;
  localparam int unsigned ASCM_B_CH_HI = 9;
  localparam int unsigned ASCM_B_CH_LO = 6;
  localparam int unsigned ASCM_B_GAIN_HI = 5;
  localparam int unsigned ASCM_B_GAIN_LO = 3;
  localparam int unsigned ASCM_B_LAST = 2;
  localparam int unsigned ASCM_B_DISCARD = 1;
  localparam int unsigned ASCM_B_SERIAL = 0;
  localparam int unsigned ASCM_B_CTRL_SRC4 = 0;

  // Reset values and reserved-bit write mask
  localparam logic [15:0] ASCM_ENTRY_RST = 16'h0000;
  localparam logic [15:0] ASCM_RSV_MASK = 16'hf3ff;
  localparam logic ASCM_SRC4_RST = 1'b0;

  typedef enum logic [2:0] {
    ASCM_MODE_DIFF,
    ASCM_MODE_GND_REF,
    ASCM_MODE_NONREF,
    ASCM_MODE_OFFSET_CAL,
    ASCM_MODE_GAIN_CAL
  } ascm_mode_t;

  typedef enum logic {
    ASCM_IDLE,
    ASCM_FETCH
  } ascm_fetch_t;

endpackage

// >>> logic/ascm_mem_if.sv
// Port group between the sequencer and the entry store
interface ascm_mem_if;
  logic we;
  logic [8:0] waddr;
  logic [15:0] wdata;
  logic re;
  logic [8:0] raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

// >>> logic/ascm_cfg_mem.sv
// Entry store of the scan list, one registered read port and one write port
module ascm_cfg_mem
  import ascm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  ascm_mem_if.mem m
);

  typedef struct packed {
    logic [ASCM_EW-1:0] rdata;
  } ascm_mem_state_t;

  logic [ASCM_EW-1:0] store [ASCM_DEPTH];
  ascm_mem_state_t s_q;
  ascm_mem_state_t s_d;

  // Array carries no reset so it can map onto block memory
  always_ff @(posedge clk_sys) begin
    if (m.we) begin
      store[m.waddr] <= m.wdata;
    end
  end

  always_comb begin
    s_d = s_q;
    if (m.re) begin
      s_d.rdata = store[m.raddr];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign m.rdata = s_q.rdata;

endmodule

// >>> logic/ascm_scan_ctrl.sv
// Scan configuration memory sequencer with APB register slave and front-end control
module ascm_scan_ctrl
  import ascm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_convert_n,
  input wire logic counter3_convert,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  output logic convert_start,
  output logic [3:0] mux_pos,
  output logic [3:0] mux_neg,
  output logic neg_from_mux,
  output logic [2:0] input_mode,
  output logic [2:0] gain_select,
  output logic [6:0] gain_factor,
  output logic polarity_bipolar,
  output logic last_in_scan,
  output logic fifo_push,
  output logic [31:0] fifo_data,
  output logic serial_push,
  output logic [15:0] serial_data
);

  typedef struct packed {
    ascm_fetch_t fsm;
    logic adv_pend;
    logic [15:0] entry;
    logic [8:0] rd_ptr;
    logic [9:0] count;
    logic conv_discard;
    logic conv_bip;
    logic conv_serial;
    logic [15:0] samples;
    logic src4;
    logic ext_prev;
    logic convert;
    logic [3:0] mux_pos;
    logic [3:0] mux_neg;
    logic neg_mux;
    ascm_mode_t mode;
    logic [6:0] gain_f;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fifo_push;
    logic [31:0] fifo_data;
    logic ser_push;
    logic [15:0] ser_data;
  } ascm_state_t;

  ascm_state_t s_q;
  ascm_state_t s_d;
  ascm_mem_if mif ();

  ////////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic ascm_mode_t ascm_mode(input logic [15:0] e);
    if (e[ASCM_B_CALIB]) begin
      ascm_mode = e[ASCM_B_SENSE] ? ASCM_MODE_GAIN_CAL : ASCM_MODE_OFFSET_CAL;
    end else if (!e[ASCM_B_SE]) begin
      ascm_mode = ASCM_MODE_DIFF;
    end else begin
      ascm_mode = e[ASCM_B_SENSE] ? ASCM_MODE_NONREF : ASCM_MODE_GND_REF;
    end
  endfunction
  function automatic logic [6:0] ascm_gain(input logic [2:0] g);
    case (g)
      3'h1: ascm_gain = 7'h01;
      3'h2: ascm_gain = 7'h02;
      3'h3: ascm_gain = 7'h05;
      3'h4: ascm_gain = 7'h0a;
      3'h5: ascm_gain = 7'h14;
      3'h6: ascm_gain = 7'h32;
      3'h7: ascm_gain = 7'h64;
      default: ascm_gain = 7'h00;
    endcase
  endfunction
  // Raw converter code is offset binary; bipolar flips the MSB into two's complement
  function automatic logic [31:0] ascm_format(input logic bip, input logic [15:0] raw);
    if (bip) begin
      ascm_format = {{17{~raw[15]}}, raw[14:0]};
    end else begin
      ascm_format = {16'h0000, raw};
    end
  endfunction
  function automatic logic ascm_hit(input logic [11:0] a, input logic [7:0] idx);
    ascm_hit = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic apb_setup;
  logic apb_access;
  logic wr_entry;
  logic mem_clear;
  logic load_req;
  logic acquisition_clear_strobe;
  logic trig;
  logic adv_req;
  logic [3:0] ch;
  logic [9:0] ptr_inc;

  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable & s_q.pready;
  assign wr_entry = apb_access & pwrite & ascm_hit(paddr, ASCM_IDX_ENTRY);
  assign mem_clear = apb_access & ~pwrite & ascm_hit(paddr, ASCM_IDX_STROBE);
  assign load_req = apb_access & pwrite & ascm_hit(paddr, ASCM_IDX_STROBE);
  assign acquisition_clear_strobe = apb_access & ~pwrite & ascm_hit(paddr, ASCM_IDX_DAQ_CLR);
  // External convert is active low; only its falling edge starts a conversion
  assign trig = (s_q.ext_prev & ~external_convert_n) | counter3_convert;
  assign adv_req = trig | load_req;
  assign ch = mif.rdata[ASCM_B_CH_HI:ASCM_B_CH_LO];
  assign ptr_inc = {1'b0, s_q.rd_ptr} + 10'h001;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.convert = 1'b0;
    s_d.fifo_push = 1'b0;
    s_d.ser_push = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.ext_prev = external_convert_n;
    mif.we = 1'b0;
    mif.waddr = s_q.count[8:0];
    mif.wdata = pwdata[15:0] & ASCM_RSV_MASK;
    mif.re = 1'b0;
    mif.raddr = s_q.rd_ptr;
    // Answer in the first access cycle
    if (apb_setup) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (ascm_hit(paddr, ASCM_IDX_STATUS) && !pwrite) begin
        s_d.prdata = {s_q.entry, 6'h00, s_q.count};
      end else if (ascm_hit(paddr, ASCM_IDX_COUNT) && !pwrite) begin
        s_d.prdata = {s_q.samples, 6'h00, (s_q.fsm == ASCM_FETCH), s_q.rd_ptr};
      end else if (ascm_hit(paddr, ASCM_IDX_CTRL)) begin
        s_d.prdata = {31'h0, s_q.src4};
      end else if (!(ascm_hit(paddr, ASCM_IDX_STROBE) ||
                     (ascm_hit(paddr, ASCM_IDX_ENTRY) && pwrite) ||
                     (ascm_hit(paddr, ASCM_IDX_DAQ_CLR) && !pwrite))) begin
        s_d.pslverr = 1'b1;
      end
    end
    if (apb_access && pwrite && ascm_hit(paddr, ASCM_IDX_CTRL)) begin
      s_d.src4 = pwdata[ASCM_B_CTRL_SRC4];
    end
    // Writes beyond the last location are dropped
    if (wr_entry && (s_q.count != ASCM_DEPTH_CNT)) begin
      mif.we = 1'b1;
      s_d.count = s_q.count + 10'h001;
    end
    if (trig) begin
      s_d.convert = 1'b1;
      s_d.conv_discard = s_q.entry[ASCM_B_DISCARD];
      s_d.conv_bip = s_q.entry[ASCM_B_BIPOLAR];
      s_d.conv_serial = s_q.entry[ASCM_B_SERIAL];
      if (!(s_q.src4 && s_q.entry[ASCM_B_DISCARD])) begin
        s_d.samples = s_q.samples + 16'h0001;
      end
    end
    // One read in flight, queued requests wait a slot; rewind drops it so nothing loads
    case (acquisition_clear_strobe ? ASCM_IDLE : s_q.fsm)
      ASCM_IDLE: begin
        if ((adv_req || s_q.adv_pend) && (s_q.count != 10'h000)) begin
          mif.re = 1'b1;
          s_d.fsm = ASCM_FETCH;
          s_d.adv_pend = 1'b0;
          s_d.rd_ptr = (ptr_inc == s_q.count) ? 9'h000 : ptr_inc[8:0];
        end
      end
      ASCM_FETCH: begin
        s_d.fsm = ASCM_IDLE;
        s_d.adv_pend = adv_req;
        s_d.entry = mif.rdata;
        s_d.mode = ascm_mode(mif.rdata);
        s_d.gain_f = ascm_gain(mif.rdata[ASCM_B_GAIN_HI:ASCM_B_GAIN_LO]);
        if (ascm_mode(mif.rdata) == ASCM_MODE_DIFF) begin
          s_d.mux_pos = {1'b0, ch[2:0]};
          s_d.mux_neg = {1'b1, ch[2:0]};
          s_d.neg_mux = 1'b1;
        end else begin
          s_d.mux_pos = ch;
          s_d.mux_neg = 4'h0;
          s_d.neg_mux = 1'b0;
        end
      end
      default: begin
        s_d.fsm = ASCM_IDLE;
      end
    endcase
    // Rewind keeps entries and leaves the applied entry in place
    if (acquisition_clear_strobe) begin
      s_d.rd_ptr = 9'h000;
      s_d.fsm = ASCM_IDLE;
      s_d.adv_pend = 1'b0;
      s_d.samples = 16'h0000;
    end
    // Old contents become unreachable and are overwritten by later writes
    if (mem_clear) begin
      s_d.count = 10'h000;
      s_d.rd_ptr = 9'h000;
      s_d.fsm = ASCM_IDLE;
      s_d.adv_pend = 1'b0;
    end
    if (adc_done) begin
      s_d.fifo_push = ~s_q.conv_discard;
      s_d.fifo_data = ascm_format(s_q.conv_bip, adc_data);
      s_d.ser_push = s_q.conv_serial;
      s_d.ser_data = adc_data ^ {s_q.conv_bip, 15'h0000};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  ascm_cfg_mem u_mem (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .m (mif.mem)
  );

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign convert_start = s_q.convert;
  assign mux_pos = s_q.mux_pos;
  assign mux_neg = s_q.mux_neg;
  assign neg_from_mux = s_q.neg_mux;
  assign input_mode = s_q.mode;
  assign gain_select = s_q.entry[ASCM_B_GAIN_HI:ASCM_B_GAIN_LO];
  assign gain_factor = s_q.gain_f;
  assign polarity_bipolar = s_q.entry[ASCM_B_BIPOLAR];
  assign last_in_scan = s_q.entry[ASCM_B_LAST];
  assign fifo_push = s_q.fifo_push;
  assign fifo_data = s_q.fifo_data;
  assign serial_push = s_q.ser_push;
  assign serial_data = s_q.ser_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence seq_advance_idle;
    adv_req && (s_q.fsm == ASCM_IDLE) && (s_q.count != 10'h000) && !acquisition_clear_strobe && !mem_clear;
  endsequence
  sequence seq_fetch_apply;
    (s_q.fsm == ASCM_FETCH) ##1 (s_q.fsm == ASCM_IDLE);
  endsequence
  property p_advance;
    seq_advance_idle |=> seq_fetch_apply;
  endproperty
  a_advance_fetch_apply: assert property (p_advance)
    else $error("advance did not fetch and apply an entry");
  a_apply_entry_value: assert property ((s_q.fsm == ASCM_FETCH) && !acquisition_clear_strobe
    && !mem_clear |=> s_q.entry == $past(mif.rdata))
    else $error("applied entry differs from stored word");
  a_discard_no_push: assert property (adc_done && s_q.conv_discard |=> !fifo_push)
    else $error("discarded result reached the FIFO");
  a_keep_push: assert property (adc_done && !s_q.conv_discard |=> fifo_push)
    else $error("kept result was not pushed");
  a_bipolar_sign_ext: assert property (adc_done && s_q.conv_bip
    |=> fifo_data[31:16] == {16{fifo_data[15]}})
    else $error("bipolar result not sign extended");
  a_unipolar_zero_ext: assert property (adc_done && !s_q.conv_bip
    |=> fifo_data == {16'h0000, $past(adc_data)})
    else $error("unipolar result not straight binary");
  a_diff_pair_map: assert property (input_mode == ASCM_MODE_DIFF && neg_from_mux
    |-> mux_neg == {1'b1, mux_pos[2:0]} && !mux_pos[3])
    else $error("differential pair mismatch");
  a_single_no_neg: assert property (input_mode != ASCM_MODE_DIFF
    |-> !neg_from_mux && (mux_neg == 4'h0))
    else $error("negative side routed outside differential mode");
  a_ptr_in_list: assert property (s_q.count != 10'h000
    |-> {1'b0, s_q.rd_ptr} < s_q.count)
    else $error("read pointer past list end");
  a_mem_clear_rewind: assert property (mem_clear
    |=> s_q.count == 10'h000 && s_q.rd_ptr == 9'h000)
    else $error("memory clear did not rewind");
  a_write_next_slot: assert property (wr_entry && (s_q.count != ASCM_DEPTH_CNT)
    && !mem_clear |=> s_q.count == $past(s_q.count) + 10'h001)
    else $error("entry write did not advance");
  a_src4_discard_hold: assert property (trig && s_q.src4 && s_q.entry[ASCM_B_DISCARD]
    && !acquisition_clear_strobe |=> $stable(s_q.samples))
    else $error("discarded conversion was counted");
  a_acquisition_clear_strobe_keeps: assert property (acquisition_clear_strobe |=> s_q.rd_ptr == 9'h000
    && $stable(s_q.count) && $stable(s_q.entry))
    else $error("acquisition clear erased or loaded");
  a_fields_hold: assert property (s_q.fsm == ASCM_IDLE |=> $stable(mux_pos)
    && $stable(gain_factor) && $stable(input_mode))
    else $error("front-end fields moved without a fetch");
endmodule

// >>> sim/ascm_fe_model.sv
// Front-end model: converter timing and result bus only, no multiplexer or gain stage
module ascm_fe_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic convert_start,
  input wire logic [3:0] conv_cycles,
  input wire logic [15:0] sample_code,
  output logic adc_done,
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] busy_q;

  // Converts every started channel, discarded or not; only the result's fate differs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_done <= 1'b0;
      // The result bus is only valid in the done cycle, so it toggles elsewhere
      adc_data <= ~adc_data;
      if (convert_start) begin
        busy_q <= conv_cycles;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
        if (busy_q == 4'h1) begin
          adc_done <= 1'b1;
          adc_data <= sample_code;
        end
      end
    end
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the scan configuration memory sequencer
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); \
  end \
end

module testbench
  import ascm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fifo_data, fifo_last;
  logic external_convert_n, counter3_convert, adc_done, convert_start;
  logic [15:0] adc_data, sample_code, serial_data, ser_last;
  logic [3:0] mux_pos, mux_neg, conv_cycles;
  logic neg_from_mux, polarity_bipolar, last_in_scan, fifo_push, serial_push;
  logic [2:0] input_mode, gain_select;
  logic [6:0] gain_factor;
  int fails = 0;
  int check_count = 0;
  int fifo_cnt = 0;
  int ser_cnt = 0;
  int conv_cnt = 0;

  ascm_scan_ctrl i_ascm_scan_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_convert_n(external_convert_n),
    .counter3_convert(counter3_convert), .adc_done(adc_done), .adc_data(adc_data),
    .convert_start(convert_start), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .neg_from_mux(neg_from_mux), .input_mode(input_mode), .gain_select(gain_select),
    .gain_factor(gain_factor), .polarity_bipolar(polarity_bipolar),
    .last_in_scan(last_in_scan), .fifo_push(fifo_push), .fifo_data(fifo_data),
    .serial_push(serial_push), .serial_data(serial_data));

  ascm_fe_model i_ascm_fe_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .convert_start(convert_start), .conv_cycles(conv_cycles), .sample_code(sample_code),
    .adc_done(adc_done), .adc_data(adc_data));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (fifo_push === 1'b1) begin
      fifo_cnt++;
      fifo_last = fifo_data;
    end
    if (serial_push === 1'b1) begin
      ser_cnt++;
      ser_last = serial_data;
    end
    if (convert_start === 1'b1) conv_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      $display("mismatch at %0t: no bus answer", $time);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
    `CHK(e, ee)
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] q, input logic ee);
    logic e;
    apb(1'b0, idx, 32'h0, q, e);
    `CHK(e, ee)
  endtask

  task automatic load();
    wr(ASCM_IDX_STROBE, 32'h0, 1'b0);
    repeat (3) @(posedge clk_sys);
  endtask

  // Clear first, then write the list, then one load to preload entry 0
  task automatic fill(input logic [15:0] l[$]);
    logic [31:0] q;
    rd(ASCM_IDX_STROBE, q, 1'b0);
    foreach (l[i]) wr(ASCM_IDX_ENTRY, {16'h0000, l[i]}, 1'b0);
    load();
  endtask

  function automatic logic [2:0] exp_mode(input logic [15:0] e);
    if (e[13]) return e[14] ? ASCM_MODE_GAIN_CAL : ASCM_MODE_OFFSET_CAL;
    if (!e[15]) return ASCM_MODE_DIFF;
    return e[14] ? ASCM_MODE_NONREF : ASCM_MODE_GND_REF;
  endfunction

  function automatic logic [6:0] exp_gain(input logic [2:0] g);
    logic [6:0] t[8] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h0a, 7'h14, 7'h32, 7'h64};
    return t[g];
  endfunction

  task automatic chk_fe(input logic [15:0] e);
    logic df;
    df = !e[13] && !e[15];
    `CHK(input_mode, exp_mode(e))
    `CHK(gain_select, e[5:3])
    `CHK(gain_factor, exp_gain(e[5:3]))
    `CHK(polarity_bipolar, e[12])
    `CHK(last_in_scan, e[2])
    if (!e[13]) `CHK(mux_pos, e[15] ? e[9:6] : {1'b0, e[8:6]})
    `CHK(mux_neg, df ? {1'b1, e[8:6]} : 4'h0)
    `CHK(neg_from_mux, df)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    rd(ASCM_IDX_CTRL, q, 1'b0);
    `CHK(q, 32'h0)
    rd(ASCM_IDX_STATUS, q, 1'b0);
    `CHK(q, 32'h0)
    rd(ASCM_IDX_ENTRY, q, 1'b1);
    rd(8'h3f, q, 1'b1);
    wr(ASCM_IDX_STATUS, 32'h1, 1'b1);
    wr(ASCM_IDX_DAQ_CLR, 32'h0, 1'b1);
    wr(ASCM_IDX_CTRL, 32'h1, 1'b0);
    rd(ASCM_IDX_CTRL, q, 1'b0);
    `CHK(q[0], 1'b1)
    $display("test regs done");
  endtask

  task automatic t_fields();
    logic [15:0] l[$] = '{16'h0208, 16'h1010, 16'h83d8, 16'hc260,
                          16'h20ec, 16'he170, 16'h01fc, 16'h8304};
    fill(l);
    for (int i = 0; i < 9; i++) begin
      chk_fe(l[i % 8]);
      load();
    end
    $display("test fields done");
  endtask

  task automatic t_single();
    fill('{16'h83dc});
    repeat (3) begin
      chk_fe(16'h83dc);
      load();
    end
    $display("test single done");
  endtask

  task automatic conv(input bit ext, input logic [3:0] cyc, input logic [15:0] raw,
                      input logic [15:0] e, input logic [15:0] nxt);
    int f0, s0, c0, n;
    logic [31:0] x;
    f0 = fifo_cnt;
    s0 = ser_cnt;
    c0 = conv_cnt;
    n = 0;
    x = e[12] ? {{16{~raw[15]}}, ~raw[15], raw[14:0]} : {16'h0000, raw};
    @(posedge clk_sys);
    conv_cycles <= cyc;
    sample_code <= raw;
    if (ext) external_convert_n <= 1'b0;
    else counter3_convert <= 1'b1;
    @(posedge clk_sys);
    external_convert_n <= 1'b1;
    counter3_convert <= 1'b0;
    while (adc_done !== 1'b1 && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    `CHK(conv_cnt - c0, 1)
    `CHK(fifo_cnt - f0, e[1] ? 0 : 1)
    `CHK(ser_cnt - s0, e[0] ? 1 : 0)
    if (!e[1]) `CHK(fifo_last, x)
    if (e[0]) `CHK(ser_last, x[15:0])
    chk_fe(nxt);
  endtask

  task automatic t_convert();
    logic [15:0] l[$] = '{16'h000d, 16'h100b, 16'h100d};
    logic [31:0] q;
    fill(l);
    wr(ASCM_IDX_CTRL, 32'h1, 1'b0);
    conv(1, 4'h1, 16'h1234, l[0], l[1]);
    conv(0, 4'h9, 16'h8001, l[1], l[2]);
    conv(0, 4'h2, 16'h700d, l[2], l[0]);
    rd(ASCM_IDX_COUNT, q, 1'b0);
    `CHK(q[31:16], 16'h0002)
    load();
    rd(ASCM_IDX_DAQ_CLR, q, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk_fe(l[1]);
    rd(ASCM_IDX_COUNT, q, 1'b0);
    `CHK(q[8:0], 9'h000)
    load();
    chk_fe(l[0]);
    $display("test convert done");
  endtask

  task automatic t_full();
    logic [31:0] q;
    rd(ASCM_IDX_STROBE, q, 1'b0);
    repeat (513) wr(ASCM_IDX_ENTRY, 32'h020c, 1'b0);
    rd(ASCM_IDX_STATUS, q, 1'b0);
    `CHK(q[9:0], ASCM_DEPTH_CNT)
    rd(ASCM_IDX_STROBE, q, 1'b0);
    rd(ASCM_IDX_STATUS, q, 1'b0);
    `CHK(q[9:0], 10'h000)
    $display("test full done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, counter3_convert} = 4'h0;
    external_convert_n = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    sample_code = 16'h0000;
    conv_cycles = 4'h1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_fields();
    t_single();
    t_convert();
    t_full();
    print_verdict();
  end
endmodule
